// [pkg/iqlw_pkg.sv]
// Types shared by the input qualifier and low-power wake sequencer.
`default_nettype none
package iqlw_pkg;
  typedef enum logic [4:0] {
    LP_RUN  = 5'h01,
    LP_IDLE = 5'h02,
    LP_HOLD = 5'h04,
    LP_STBY = 5'h08,
    LP_WAKE = 5'h10
  } iqlw_lp_state_t;
  typedef struct packed {
    logic [1:0][7:0] sample_period_divider;
    logic [15:0]     qualify_sample_count_select;
    logic [15:0]     qualify_enable;
  } iqlw_qual_cfg_t;
  typedef struct packed {
    logic       standby_select;
    logic       flash_sleep;
    logic [1:0] clock_divider_select;
    logic       standby_qualify_enable;
    logic [5:0] standby_wake_qualify_count;
    logic       wake_irq_enable;
  } iqlw_lp_cfg_t;
  typedef struct packed {
    logic enabled_interrupt;
    logic watchdog_interrupt;
    logic nonmaskable_interrupt_input;
    logic reset_input_pin;
    logic standby_wake_pin;
  } iqlw_wake_t;
  typedef struct packed {
    logic system_clock_run;
    logic peripheral_clock_run;
    logic pll_run;
    logic watchdog_run;
    logic clock_output_pin;
    logic execution_resume;
    logic service_wake_irq;
    logic in_low_power;
  } iqlw_lp_out_t;
endpackage
`default_nettype wire

// [pkg/iqlw_regs.svh]
// Constants for the input qualifier and low-power wake sequencer.
// Notes on behaviour
// - Divider zero samples every system clock.
// - Divider n samples every 2n clocks.
// - Divider is eight bits, zero to 0xFF.
// - One divider setting per group of eight pins.
// - Per-pin select picks three or six samples.
// - Three samples span two sampling periods.
// - Six samples span five sampling periods.
// - Glitches shorter than the window are ignored.
// - Idle exits on interrupt, watchdog, NMI, reset.
// - Idle resume 20 clocks, 1050 flash asleep.
// - Latency counts to the next instruction.
// - Standby wake pulse: three, or 2+count.
// - Standby clock hold 16, 32 or 64.
// - Standby stops peripherals, keeps PLL, watchdog.
// - Clock output low 32 to 45 clocks.
// - Standby resume 100 clocks, 1125 flash asleep.
// - Service the waking interrupt: after idle unless the reset pin woke it, after standby only when enabled.
`ifndef IQLW_REGS_SVH
`define IQLW_REGS_SVH
`define IQLW_PINS           16
`define IQLW_GROUP_PINS     8
`define IQLW_GROUPS         2
`define IQLW_CLK_PERIOD_NS  10
`define IQLW_IDLE_RESUME    11'h014
`define IQLW_IDLE_RES_SLEEP 11'h41A
`define IQLW_STBY_RESUME    11'h064
`define IQLW_STBY_RES_SLEEP 11'h465
`define IQLW_CLKOUT_LOW_MIN 11'h020
`define IQLW_CLKOUT_LOW_MAX 11'h02D
`define IQLW_HOLD_SHORT     11'h010
`define IQLW_HOLD_MID       11'h020
`define IQLW_HOLD_LONG      11'h040
`define IQLW_WAKE_GAP_OSC   3'h4
`define IQLW_STBY_WAKE_UNQ  7'h03
`define IQLW_STBY_WAKE_BASE 7'h02
`endif

// [src/iqlw_top.sv]
// Input qualifier for sixteen pins and the idle/standby wake sequencer.
`timescale 1ns/1ns
`default_nettype none
`include "iqlw_regs.svh"

module iqlw_top
(
  input  wire logic                    sys_clk,
  input  wire logic                    sys_rst,
  input  wire logic [15:0]             pin_in,
  input  wire iqlw_pkg::iqlw_qual_cfg_t qual_cfg,
  input  wire iqlw_pkg::iqlw_lp_cfg_t   lp_cfg,
  input  wire iqlw_pkg::iqlw_wake_t     wake,
  input  wire logic                    idle_exec,
  input  wire logic                    oscillator_clock_tick,
  output logic [15:0]                  pin_qualified,
  output iqlw_pkg::iqlw_lp_out_t        lp_out
);
  import iqlw_pkg::*;

  typedef struct packed {
    logic [1:0][8:0]  div_cnt;
    logic [15:0][5:0] samples;
    logic [15:0]      qual;
    iqlw_lp_state_t   lp_state;
    logic [10:0]      lp_cnt;
    logic [2:0]       osc_cnt;
    logic [6:0]       wake_cnt;
    logic             wake_irq;
    logic [10:0]      chk_age;
    logic             chk_stby;
    logic             chk_slow;
    iqlw_lp_out_t     out;
  } iqlw_state_t;

  iqlw_state_t st_reg;
  iqlw_state_t st_next;
  logic [1:0]  tick;
  logic [10:0] hold_len;
  logic [6:0]  stby_need;
  logic        idle_wake;
  logic        stby_wake;

  ////////////////////////////////////////////////////////////////////////
  // Sampling strobes, one per group of eight pins.

  always_comb
  begin
    for (int g = 0; g < `IQLW_GROUPS; g++)
    begin
      if (qual_cfg.sample_period_divider[g] == 8'h00)
      begin
        tick[g] = 1'b1;
      end
      else
      begin
        // A divider lowered in mid-count restarts at once instead of wrapping.
        tick[g] = (st_reg.div_cnt[g] >=
                   9'({qual_cfg.sample_period_divider[g], 1'b0} - 9'h001));
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Low-power helpers.

  always_comb
  begin
    case (lp_cfg.clock_divider_select)
      2'b10:   hold_len = `IQLW_HOLD_MID;
      2'b11:   hold_len = `IQLW_HOLD_LONG;
      default: hold_len = `IQLW_HOLD_SHORT;
    endcase
  end

  // Wake pulses are counted in oscillator cycles because the system
  // clock may be stopped while standby waits for them.
  assign stby_need = lp_cfg.standby_qualify_enable ?
                     7'(`IQLW_STBY_WAKE_BASE + {1'b0, lp_cfg.standby_wake_qualify_count}) :
                     `IQLW_STBY_WAKE_UNQ;

  // A wake during the first oscillator cycles after entry is not honoured.
  assign idle_wake = (st_reg.lp_state == LP_IDLE) &&
                     (st_reg.osc_cnt >= `IQLW_WAKE_GAP_OSC) &&
                     (wake.enabled_interrupt || wake.watchdog_interrupt ||
                      wake.nonmaskable_interrupt_input || wake.reset_input_pin);
  assign stby_wake = (st_reg.lp_state == LP_STBY) &&
                     (st_reg.osc_cnt >= `IQLW_WAKE_GAP_OSC) &&
                     ((st_reg.wake_cnt >= stby_need) || wake.reset_input_pin);

  ////////////////////////////////////////////////////////////////////////
  // Next state.

  always_comb
  begin
    st_next = st_reg;
    st_next.out.execution_resume = 1'b0;
    st_next.out.service_wake_irq = 1'b0;

    for (int g = 0; g < `IQLW_GROUPS; g++)
    begin
      st_next.div_cnt[g] = tick[g] ? 9'h000 : 9'(st_reg.div_cnt[g] + 9'h001);
    end

    for (int p = 0; p < `IQLW_PINS; p++)
    begin
      if (!qual_cfg.qualify_enable[p])
      begin
        st_next.qual[p] = pin_in[p];
        st_next.samples[p] = {6{pin_in[p]}};
      end
      else if (tick[p / `IQLW_GROUP_PINS])
      begin
        st_next.samples[p] = {st_reg.samples[p][4:0], pin_in[p]};
        if (qual_cfg.qualify_sample_count_select[p])
        begin
          if (st_next.samples[p] == 6'h00 || st_next.samples[p] == 6'h3F)
          begin
            st_next.qual[p] = st_next.samples[p][0];
          end
        end
        else
        begin
          if (st_next.samples[p][2:0] == 3'h0 || st_next.samples[p][2:0] == 3'h7)
          begin
            st_next.qual[p] = st_next.samples[p][0];
          end
        end
      end
    end

    if (oscillator_clock_tick && st_reg.osc_cnt < `IQLW_WAKE_GAP_OSC)
    begin
      st_next.osc_cnt = 3'(st_reg.osc_cnt + 3'h1);
    end

    if (!wake.standby_wake_pin)
    begin
      st_next.wake_cnt = 7'h00;
    end
    else if (oscillator_clock_tick && st_reg.wake_cnt != 7'h7F)
    begin
      st_next.wake_cnt = 7'(st_reg.wake_cnt + 7'h01);
    end

    // Cycles since the last accepted wake, read only by the latency checks;
    // it drives no output, so it costs nothing in the datapath.
    if (idle_wake || stby_wake)
    begin
      st_next.chk_age = 11'h001;
      st_next.chk_stby = stby_wake;
      st_next.chk_slow = lp_cfg.flash_sleep;
    end
    else if (st_reg.chk_age != 11'h000 && st_reg.chk_age != 11'h7FF)
    begin
      st_next.chk_age = 11'(st_reg.chk_age + 11'h001);
    end

    case (st_reg.lp_state)
      LP_RUN:
      begin
        if (idle_exec)
        begin
          st_next.osc_cnt = 3'h0;
          st_next.lp_cnt = 11'h000;
          st_next.out.in_low_power = 1'b1;
          st_next.lp_state = lp_cfg.standby_select ? LP_HOLD : LP_IDLE;
        end
      end
      LP_IDLE:
      begin
        if (idle_wake)
        begin
          st_next.wake_irq = wake.enabled_interrupt || wake.watchdog_interrupt ||
                             wake.nonmaskable_interrupt_input;
          st_next.lp_cnt = lp_cfg.flash_sleep ?
                           11'(`IQLW_IDLE_RES_SLEEP - 11'h002) :
                           11'(`IQLW_IDLE_RESUME - 11'h002);
          st_next.lp_state = LP_WAKE;
        end
      end
      LP_HOLD:
      begin
        // The system clock keeps running so the pipeline can drain. The count
        // runs up to the selected hold, reaching the clock output point for holds of 32 and 64.
        if (st_reg.lp_cnt < hold_len)
        begin
          st_next.lp_cnt = 11'(st_reg.lp_cnt + 11'h001);
        end
        if (st_reg.lp_cnt == 11'(`IQLW_CLKOUT_LOW_MIN - 11'h002))
        begin
          st_next.out.clock_output_pin = 1'b0;
        end
        if (st_reg.lp_cnt == 11'(hold_len - 11'h002))
        begin
          st_next.out.system_clock_run = 1'b0;
          st_next.out.peripheral_clock_run = 1'b0;
          st_next.lp_state = LP_STBY;
        end
      end
      LP_STBY:
      begin
        // An external access longer than the hold is lost; software must
        // enter standby with none outstanding.
        if (st_reg.lp_cnt < `IQLW_CLKOUT_LOW_MIN)
        begin
          st_next.lp_cnt = 11'(st_reg.lp_cnt + 11'h001);
        end
        if (st_reg.lp_cnt == 11'(`IQLW_CLKOUT_LOW_MIN - 11'h002))
        begin
          st_next.out.clock_output_pin = 1'b0;
        end
        if (stby_wake)
        begin
          st_next.wake_irq = lp_cfg.wake_irq_enable && !wake.reset_input_pin;
          st_next.out.system_clock_run = 1'b1;
          st_next.out.peripheral_clock_run = 1'b1;
          st_next.out.clock_output_pin = 1'b1;
          st_next.lp_cnt = lp_cfg.flash_sleep ?
                           11'(`IQLW_STBY_RES_SLEEP - 11'h002) :
                           11'(`IQLW_STBY_RESUME - 11'h002);
          st_next.lp_state = LP_WAKE;
        end
      end
      LP_WAKE:
      begin
        if (st_reg.lp_cnt == 11'h000)
        begin
          st_next.out.execution_resume = 1'b1;
          st_next.out.service_wake_irq = st_reg.wake_irq;
          st_next.out.in_low_power = 1'b0;
          st_next.lp_state = LP_RUN;
        end
        else
        begin
          st_next.lp_cnt = 11'(st_reg.lp_cnt - 11'h001);
        end
      end
      default:
      begin
        st_next.lp_state = LP_RUN;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // State register.

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      st_reg <= '0;
      st_reg.lp_state <= LP_RUN;
      st_reg.out.system_clock_run <= 1'b1;
      st_reg.out.peripheral_clock_run <= 1'b1;
      st_reg.out.pll_run <= 1'b1;
      st_reg.out.watchdog_run <= 1'b1;
      st_reg.out.clock_output_pin <= 1'b1;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign pin_qualified = st_reg.qual;
  assign lp_out = st_reg.out;

  ////////////////////////////////////////////////////////////////////////
  // Checks.

  logic go_stby;
  logic go_idle_wake;
  assign go_stby = (st_reg.lp_state == LP_RUN) && idle_exec && lp_cfg.standby_select;
  assign go_idle_wake = idle_wake;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  a_div_zero_tick: assert property (
    (qual_cfg.sample_period_divider[0] == 8'h00 && qual_cfg.qualify_enable[0])
    |=> st_reg.samples[0][0] == $past(pin_in[0]))
    else $error("zero divider did not sample every cycle");

  a_div_one_period: assert property (
    (tick[1] && qual_cfg.sample_period_divider[1] == 8'h01 ##1
     qual_cfg.sample_period_divider[1] == 8'h01 ##1
     qual_cfg.sample_period_divider[1] == 8'h01)
    |-> tick[1] && !$past(tick[1]))
    else $error("divider one did not sample every two cycles");

  a_qual_three_agree: assert property (
    (qual_cfg.qualify_enable[0] && !qual_cfg.qualify_sample_count_select[0] &&
     $stable(qual_cfg.qualify_enable[0]) && $changed(pin_qualified[0]))
    |-> st_reg.samples[0][2:0] == {3{pin_qualified[0]}})
    else $error("three-sample qualifier changed without agreement");

  a_qual_six_agree: assert property (
    (qual_cfg.qualify_enable[1] && qual_cfg.qualify_sample_count_select[1] &&
     $stable(qual_cfg.qualify_enable[1]) && $changed(pin_qualified[1]))
    |-> st_reg.samples[1] == {6{pin_qualified[1]}})
    else $error("six-sample qualifier changed without agreement");

  a_idle_resume: assert property (
    (go_idle_wake && !lp_cfg.flash_sleep) |-> ##20 lp_out.execution_resume)
    else $error("idle resume not after twenty cycles");

  a_idle_resume_slp: assert property (
    (st_reg.chk_age == `IQLW_IDLE_RES_SLEEP && !st_reg.chk_stby && st_reg.chk_slow)
    |-> lp_out.execution_resume)
    else $error("idle resume with sleeping flash late");

  a_stby_resume: assert property (
    (stby_wake && !lp_cfg.flash_sleep) |-> ##100 lp_out.execution_resume)
    else $error("standby resume not after one hundred cycles");

  a_stby_resume_slp: assert property (
    (st_reg.chk_age == `IQLW_STBY_RES_SLEEP && st_reg.chk_stby && st_reg.chk_slow)
    |-> lp_out.execution_resume)
    else $error("standby resume with sleeping flash late");

  a_clkout_low: assert property (
    (go_stby && !wake.reset_input_pin)
    |-> ##31 lp_out.clock_output_pin ##1 !lp_out.clock_output_pin)
    else $error("clock output did not go low at cycle thirty-two");

  a_hold_long: assert property (
    (go_stby && lp_cfg.clock_divider_select == 2'b11)
    |-> ##63 lp_out.system_clock_run ##1 !lp_out.system_clock_run)
    else $error("system clock hold for divider select three wrong");

  a_hold_mid: assert property (
    (go_stby && lp_cfg.clock_divider_select == 2'b10)
    |-> ##31 lp_out.system_clock_run ##1 !lp_out.system_clock_run)
    else $error("system clock hold for divider select two wrong");

  a_hold_short: assert property (
    (go_stby && !lp_cfg.clock_divider_select[1])
    |-> ##15 lp_out.system_clock_run ##1 !lp_out.system_clock_run)
    else $error("system clock hold for divider select zero or one wrong");

  a_stby_clocks: assert property (
    (st_reg.lp_state == LP_STBY)
    |-> !lp_out.peripheral_clock_run && lp_out.pll_run && lp_out.watchdog_run)
    else $error("standby clock gating wrong");

  a_wake_gap: assert property (
    (st_reg.lp_state == LP_IDLE && st_reg.osc_cnt < `IQLW_WAKE_GAP_OSC)
    |=> st_reg.lp_state != LP_WAKE)
    else $error("wake accepted too soon after entry");

  a_service_irq: assert property (
    lp_out.service_wake_irq |-> lp_out.execution_resume && $past(st_reg.wake_irq))
    else $error("interrupt serviced without a waking interrupt");

endmodule

`default_nettype wire

// [testbench/input_qualifier_lowpower_wake_tb.sv]
// Self-checking bench for the input qualifier and low-power wake sequencer.
`timescale 1ns/1ns
`default_nettype none
module input_qualifier_lowpower_wake_tb;
  import iqlw_pkg::*;
  logic           sys_clk = 1'b0;
  logic           sys_rst = 1'b1;
  logic           idle_exec = 1'b0;
  logic [15:0]    pin_in;
  logic [15:0]    pin_qualified;
  logic [15:0]    seen = 16'h0000;
  logic           osc_tick;
  iqlw_qual_cfg_t qual_cfg;
  iqlw_lp_cfg_t   lp_cfg;
  iqlw_wake_t     wake;
  iqlw_lp_out_t   lp_out;
  int             mismatches = 0;
  int             n_tests = 0;
  initial forever #5 sys_clk = ~sys_clk;
  iqlw_src src (.sys_clk(sys_clk), .pin_in(pin_in), .wake(wake), .osc_tick(osc_tick));
  iqlw_top uut (.sys_clk(sys_clk), .sys_rst(sys_rst), .pin_in(pin_in), .qual_cfg(qual_cfg),
    .lp_cfg(lp_cfg), .wake(wake), .idle_exec(idle_exec), .oscillator_clock_tick(osc_tick),
    .pin_qualified(pin_qualified), .lp_out(lp_out));
  // A pulse may be accepted and dropped again before the end, so keep a sticky record.
  always @(posedge sys_clk) seen <= seen | pin_qualified;
  //////////////////////////////////////////////////////////////////////////////
  task automatic chk_vec(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      mismatches++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_rng(input int k, input int lo, input int hi);
    n_tests++;
    if (k < lo || k > hi)
    begin
      mismatches++;
      $display("MISMATCH at %0t: count %0d not in %0d..%0d", $time, k, lo, hi);
    end
  endtask
  task automatic close_out();
    $display("mismatches %0d comparisons %0d", mismatches, n_tests);
    if (mismatches == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  // Pins 0,1 use divider 0, pin 2 is unqualified, pins 8,9 the varied one; 1 and 9 take six samples.
  task automatic qual(input logic [7:0] d1, input int len, input logic [15:0] exp);
    int p;
    p = (d1 == 8'h00) ? 1 : 2 * d1;
    qual_cfg.sample_period_divider[1] = d1;
    src.drive_pins(16'h0000, 4 * p + 8);
    seen = 16'h0000;
    src.drive_pins(16'h0307, len);
    src.drive_pins(16'h0000, 4 * p + 8);
    chk_vec(seen, exp);
    chk_vec(pin_qualified, 16'h0000);
  endtask
  task automatic wait_res(output int k, output logic svc);
    k = 0;
    while (lp_out.execution_resume !== 1'b1 && k < 1300)
    begin
      @(negedge sys_clk);
      k++;
    end
    svc = lp_out.service_wake_irq;
  endtask
  task automatic idle_case(input iqlw_wake_t w, input logic fl);
    int k;
    logic svc;
    lp_cfg.standby_select = 1'b0;
    lp_cfg.flash_sleep = fl;
    idle_exec = 1'b1;
    @(negedge sys_clk);
    idle_exec = 1'b0;
    src.drive_wake(w, 1);
    repeat (30) @(negedge sys_clk);
    chk_vec({15'h0000, lp_out.in_low_power}, 16'h0001);
    src.wake = w;
    wait_res(k, svc);
    src.wake = '0;
    chk_rng(k, fl ? 1048 : 18, fl ? 1050 : 20);
    chk_vec({15'h0000, svc}, {15'h0000, ~w.reset_input_pin});
  endtask
  task automatic stby_case(input logic [1:0] ds, input logic qe, input logic fl, input logic ie);
    int k;
    int h;
    int hl;
    int x;
    int need;
    logic svc;
    need = qe ? 7 : 3;
    lp_cfg = '{1'b1, fl, ds, qe, 6'h05, ie};
    hl = ds == 2'h3 ? 64 : ds == 2'h2 ? 32 : 16;
    idle_exec = 1'b1;
    h = 0;
    x = 0;
    for (int i = 1; i <= 80; i++)
    begin
      @(negedge sys_clk);
      idle_exec = 1'b0;
      if (h == 0 && lp_out.system_clock_run !== 1'b1) h = i;
      if (x == 0 && lp_out.clock_output_pin !== 1'b1) x = i;
    end
    chk_rng(h, hl, hl);
    chk_rng(x, 32, 45);
    chk_vec({13'h0000, lp_out.peripheral_clock_run, lp_out.pll_run, lp_out.watchdog_run},
      16'h0003);
    // One tick short of the need is a pulse the sequencer must not take.
    src.drive_wake(5'h01, 4 * need - 4);
    repeat (20) @(negedge sys_clk);
    chk_vec({15'h0000, lp_out.in_low_power}, 16'h0001);
    src.wake.standby_wake_pin = 1'b1;
    wait_res(k, svc);
    src.wake = '0;
    chk_rng(k, 100, (fl ? 1125 : 100) + 4 * need + 1);
    chk_vec({15'h0000, svc}, {15'h0000, ie});
    @(negedge sys_clk);
    chk_vec({15'h0000, lp_out.system_clock_run}, 16'h0001);
    chk_vec({14'h0000, lp_out.clock_output_pin, lp_out.in_low_power}, 16'h0002);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    qual_cfg = {16'h0000, 16'h0202, 16'hFFFB};
    lp_cfg = '0;
    repeat (16) @(negedge sys_clk);
    chk_vec({8'h00, lp_out}, 16'h00F8);
    chk_vec(pin_qualified, 16'h0000);
    sys_rst = 1'b0;
    qual(8'h00, 2, 16'h0004);
    qual(8'h00, 3, 16'h0105);
    qual(8'h00, 5, 16'h0105);
    qual(8'h00, 6, 16'h0307);
    qual(8'h01, 3, 16'h0005);
    qual(8'h01, 7, 16'h0107);
    qual(8'hFF, 1020, 16'h0007);
    qual(8'hFF, 1531, 16'h0107);
    for (int i = 0; i < 4; i++)
      idle_case(iqlw_wake_t'(5'h10 >> i), i == 3);
    for (int i = 0; i < 4; i++)
      stby_case(2'(i), i[0], i == 3, i[1]);
    close_out();
  end
  // The tests need about 14000 cycles; this limit leaves a wide margin.
  initial
  begin
    #600000;
    mismatches++;
    close_out();
  end
endmodule
`default_nettype wire

// [testbench/iqlw_src.sv]
// Model of the external sources that drive the pins, wake lines and oscillator tick.
`timescale 1ns/1ns
`default_nettype none
module iqlw_src
(
  input  wire logic                 sys_clk,
  output var  logic [15:0]          pin_in,
  output var  iqlw_pkg::iqlw_wake_t wake,
  output var  logic                 osc_tick
);
  import iqlw_pkg::*;
  logic [1:0] osc_div_reg = 2'h0;
  initial
  begin
    pin_in = 16'h0000;
    wake = '0;
    osc_tick = 1'b0;
  end
  //////////////////////////////////////////////////////////////////////////////
  // The oscillator runs at a quarter of the system rate, so tick counts map to cycles.
  always @(negedge sys_clk)
  begin
    osc_div_reg <= osc_div_reg + 2'h1;
    osc_tick <= (osc_div_reg == 2'h3);
  end
  // Levels change at falling edges only and are held for whole cycles.
  task automatic drive_pins(input logic [15:0] v, input int n);
    pin_in = v;
    repeat (n) @(negedge sys_clk);
  endtask
  task automatic drive_wake(input iqlw_wake_t w, input int n);
    wake = w;
    repeat (n) @(negedge sys_clk);
    wake = '0;
  endtask
endmodule
`default_nettype wire
